// File: logic/vbr_pkg.sv
package vbr_pkg;

  // ==========================================================
  // Register map, byte addresses on the APB port.
  // ==========================================================
  localparam logic [11:0] VBR_OFS_CCV_CTRL = 12'h000; // Chroma conversion enable.
  localparam logic [11:0] VBR_OFS_CCV_MODE = 12'h004; // Chroma conversion variants.
  localparam logic [11:0] VBR_OFS_LUT0 = 12'h010; // Blend entry zero.
  localparam logic [11:0] VBR_OFS_LUT1 = 12'h014; // Blend entry one.
  localparam logic [11:0] VBR_OFS_LUT2 = 12'h018; // Blend entry two.
  localparam logic [11:0] VBR_OFS_LUT3 = 12'h01c; // Blend entry three.
  localparam logic [11:0] VBR_OFS_RANGE = 12'h020; // Range mapping control.
  localparam logic [11:0] VBR_OFS_LUMA_PAD = 12'h024; // Luma padding widths.
  localparam logic [11:0] VBR_OFS_CHROMA_PAD = 12'h028; // Chroma padding widths.

  // ==========================================================
  // Field positions.
  // ==========================================================
  localparam int VBR_POS_CCV_EN = 0; // Enable bit in the control register.
  localparam int VBR_POS_SRC_VAR = 1; // Source codec variant bit.
  localparam int VBR_POS_RES_VAR = 0; // Result codec variant bit.
  localparam int VBR_POS_RM_C_EN = 11; // Chroma range-map enable.
  localparam int VBR_POS_RM_C_LSB = 8; // Chroma coefficient, bits 10-8.
  localparam int VBR_POS_RM_Y_EN = 3; // Luma range-map enable.
  localparam int VBR_POS_RM_Y_LSB = 0; // Luma coefficient, bits 2-0.
  localparam int VBR_POS_PAD_V_LSB = 8; // Vertical width, bits 13-8.
  localparam int VBR_POS_PAD_H_LSB = 0; // Horizontal width, bits 5-0.

  // ==========================================================
  // Reset values and widths.
  // ==========================================================
  localparam logic [31:0] VBR_RST_WORD = 32'h0000_0000; // Every field resets to zero.
  localparam int VBR_COEF_W = 3; // Range-map coefficient width.
  localparam int VBR_PAD_W = 6; // Padding width field size.

  // One blend look-up entry, laid out as in the register.
  typedef struct packed {
    logic [7:0] blend_factor;
    logic [7:0] blend_luma_value;
    logic [7:0] blend_cb_value;
    logic [7:0] blend_cr_value;
  } vbr_blend_t;

  // Effective range-mapping settings seen by the datapath.
  typedef struct packed {
    logic chroma_en;
    logic [VBR_COEF_W-1:0] chroma_coef;
    logic luma_en;
    logic [VBR_COEF_W-1:0] luma_coef;
  } vbr_range_t;

  // Padding widths of one plane.
  typedef struct packed {
    logic [VBR_PAD_W-1:0] vert_total;
    logic [VBR_PAD_W-1:0] horiz_side;
  } vbr_pad_t;

  // Replicated field coordinate.
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } vbr_coord_t;

endpackage : vbr_pkg

// File: logic/vbr_blend_pick.sv
`timescale 1ns/10ps
// Registered selection of one blend entry by the 2-bit bitmap index.
module vbr_blend_pick (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Table and index.
  input vbr_pkg::vbr_blend_t lut [4],
  input wire logic [1:0] bmp_index,
  // Selected entry.
  output vbr_pkg::vbr_blend_t entry_ff
);
  import vbr_pkg::*;

  // ==========================================================
  // Index 00b picks entry zero, up to 11b for entry three.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      entry_ff <= vbr_blend_t'(VBR_RST_WORD);
    end
    else
    begin
      entry_ff <= lut[bmp_index];
    end
  end

  chk_index_select: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 entry_ff == $past(lut[bmp_index]))
    else $error("Blend entry does not follow the index.");

endmodule : vbr_blend_pick

// File: logic/vbr_pad_clamp.sv
`timescale 1ns/10ps
// Maps a coordinate in the padded field onto the original field, clamping
// to the nearest edge so that padding replicates edge pixels.
module vbr_pad_clamp #(
  parameter int COORD_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Padding widths and field size.
  input vbr_pkg::vbr_pad_t pad,
  input wire logic [COORD_W-1:0] field_width,
  input wire logic [COORD_W-1:0] field_height,
  // Coordinate in the padded field.
  input wire logic [COORD_W-1:0] pad_x,
  input wire logic [COORD_W-1:0] pad_y,
  // Source coordinate in the original field.
  output logic [COORD_W-1:0] src_x_ff,
  output logic [COORD_W-1:0] src_y_ff
);
  import vbr_pkg::*;

  // Clamps one axis: subtract the leading margin, then hold at the edges.
  function automatic logic [COORD_W-1:0] clamp_axis(input logic [COORD_W-1:0] pos,
                                                    input logic [COORD_W-1:0] margin,
                                                    input logic [COORD_W-1:0] size);
    logic [COORD_W-1:0] rel;
    rel = pos - margin;
    if (pos < margin || size == '0)
      clamp_axis = '0;
    else if (rel >= size)
      clamp_axis = size - 1'b1;
    else
      clamp_axis = rel;
  endfunction : clamp_axis

  logic [COORD_W-1:0] top_margin; // Rows added above the field.
  logic [COORD_W-1:0] side_margin; // Columns added to the left.

  // Half of the vertical total goes above, full horizontal to each side.
  assign top_margin = COORD_W'(pad.vert_total >> 1);
  assign side_margin = COORD_W'(pad.horiz_side);

  // ==========================================================
  // Registered edge replication.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_x_ff <= '0;
      src_y_ff <= '0;
    end
    else
    begin
      src_x_ff <= clamp_axis(pad_x, side_margin, field_width);
      src_y_ff <= clamp_axis(pad_y, top_margin, field_height);
    end
  end

  chk_left_edge_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_x < side_margin) |=> (src_x_ff == '0))
    else $error("Left padding does not copy the edge column.");

  chk_top_edge_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_y < top_margin) |=> (src_y_ff == '0))
    else $error("Top padding does not copy the edge row.");

  chk_inner_pixel: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_x >= side_margin && pad_x - side_margin < field_width)
    |=> (src_x_ff == $past(pad_x) - $past(side_margin)))
    else $error("Inner column is not passed through.");

endmodule : vbr_pad_clamp

// File: logic/vbr_cfg_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
// ==========================================================
// ==========================================================
module vbr_cfg_top #(
  parameter int COORD_W = 12
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Blend look-up request.
  input wire logic [1:0] bmp_index,
  output vbr_pkg::vbr_blend_t blend_entry,
  // Chroma conversion effective variants.
  output logic chroma_conv_enable,
  output logic chroma_conv_source_variant,
  output logic chroma_conv_result_variant,
  // Range mapping effective settings.
  output vbr_pkg::vbr_range_t range_cfg,
  // Padding widths for the datapath.
  output vbr_pkg::vbr_pad_t luma_pad,
  output vbr_pkg::vbr_pad_t chroma_pad,
  // Edge replication request.
  input wire logic pad_is_chroma,
  input wire logic [COORD_W-1:0] field_width,
  input wire logic [COORD_W-1:0] field_height,
  input wire logic [COORD_W-1:0] pad_x,
  input wire logic [COORD_W-1:0] pad_y,
  output logic [COORD_W-1:0] src_x,
  output logic [COORD_W-1:0] src_y
);
  import vbr_pkg::*;

  // ==========================================================
  // Storage.
  // ==========================================================
  logic ccv_en_ff; // Chroma conversion enable.
  logic [1:0] ccv_mode_ff; // Source and result variant bits.
  vbr_blend_t lut_ff [4]; // Blend look-up entries.
  logic rm_c_en_ff; // Chroma range-map enable.
  logic [VBR_COEF_W-1:0] rm_c_coef_ff; // Chroma coefficient.
  logic rm_y_en_ff; // Luma range-map enable.
  logic [VBR_COEF_W-1:0] rm_y_coef_ff; // Luma coefficient.
  vbr_pad_t luma_pad_ff; // Luma padding widths.
  vbr_pad_t chroma_pad_ff; // Chroma padding widths.

  // Bus handshake state.
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic setup_phase; // Setup cycle of a transfer.
  logic wr_commit; // Write takes effect on this edge.
  logic addr_hit; // Address decodes to a register.
  logic [31:0] nxt_rdata; // Read value of the addressed register.

  // Outputs held in flip-flops, and the combinational pad select.
  logic ccv_en_out_ff;
  logic src_var_ff;
  logic res_var_ff;
  vbr_range_t range_ff;
  vbr_pad_t sel_pad; // Padding of the plane being replicated.

  // Packs a pad register into its bus word; reserved bits read zero.
  function automatic logic [31:0] pad_word(input vbr_pad_t p);
    pad_word = {18'h0, p.vert_total, 2'h0, p.horiz_side};
  endfunction : pad_word

  // Unpacks a bus word into pad widths.
  function automatic vbr_pad_t pad_from(input logic [31:0] w);
    pad_from.vert_total = w[VBR_POS_PAD_V_LSB +: VBR_PAD_W];
    pad_from.horiz_side = w[VBR_POS_PAD_H_LSB +: VBR_PAD_W];
  endfunction : pad_from

  assign setup_phase = psel && !penable;
  assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff;

  // ==========================================================
  // Address decode and read multiplexer.
  // ==========================================================
  always_comb
  begin
    addr_hit = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      VBR_OFS_CCV_CTRL: nxt_rdata[VBR_POS_CCV_EN] = ccv_en_ff;
      VBR_OFS_CCV_MODE: nxt_rdata[1:0] = ccv_mode_ff;
      VBR_OFS_LUT0: nxt_rdata = lut_ff[0];
      VBR_OFS_LUT1: nxt_rdata = lut_ff[1];
      VBR_OFS_LUT2: nxt_rdata = lut_ff[2];
      VBR_OFS_LUT3: nxt_rdata = lut_ff[3];
      VBR_OFS_RANGE:
      begin
        nxt_rdata[VBR_POS_RM_C_EN] = rm_c_en_ff;
        nxt_rdata[VBR_POS_RM_C_LSB +: VBR_COEF_W] = rm_c_coef_ff;
        nxt_rdata[VBR_POS_RM_Y_EN] = rm_y_en_ff;
        nxt_rdata[VBR_POS_RM_Y_LSB +: VBR_COEF_W] = rm_y_coef_ff;
      end
      VBR_OFS_LUMA_PAD: nxt_rdata = pad_word(luma_pad_ff);
      VBR_OFS_CHROMA_PAD: nxt_rdata = pad_word(chroma_pad_ff);
      default: addr_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // APB answer: ready one cycle after setup, no wait states.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= VBR_RST_WORD;
    end
    else if (setup_phase)
    begin
      // Capture the answer so that the access phase completes at once.
      pready_ff <= 1'b1;
      pslverr_ff <= !addr_hit;
      prdata_ff <= (addr_hit && !pwrite) ? nxt_rdata : 32'h0000_0000;
    end
    else
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================
  // Chroma conversion registers.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ccv_en_ff <= 1'b0;
      ccv_mode_ff <= 2'h0;
    end
    else if (wr_commit && paddr == VBR_OFS_CCV_CTRL)
    begin
      ccv_en_ff <= pwdata[VBR_POS_CCV_EN];
    end
    else if (wr_commit && paddr == VBR_OFS_CCV_MODE)
    begin
      ccv_mode_ff <= pwdata[1:0];
    end
  end

  // ==========================================================
  // Blend look-up entries, every field read/write.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        lut_ff[i] <= vbr_blend_t'(VBR_RST_WORD);
    end
    else if (wr_commit)
    begin
      unique case (paddr)
        VBR_OFS_LUT0: lut_ff[0] <= vbr_blend_t'(pwdata);
        VBR_OFS_LUT1: lut_ff[1] <= vbr_blend_t'(pwdata);
        VBR_OFS_LUT2: lut_ff[2] <= vbr_blend_t'(pwdata);
        VBR_OFS_LUT3: lut_ff[3] <= vbr_blend_t'(pwdata);
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // Range mapping control; software mirrors the stream flags.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rm_c_en_ff <= 1'b0;
      rm_c_coef_ff <= '0;
      rm_y_en_ff <= 1'b0;
      rm_y_coef_ff <= '0;
    end
    else if (wr_commit && paddr == VBR_OFS_RANGE)
    begin
      rm_c_en_ff <= pwdata[VBR_POS_RM_C_EN];
      rm_c_coef_ff <= pwdata[VBR_POS_RM_C_LSB +: VBR_COEF_W];
      rm_y_en_ff <= pwdata[VBR_POS_RM_Y_EN];
      rm_y_coef_ff <= pwdata[VBR_POS_RM_Y_LSB +: VBR_COEF_W];
    end
  end

  // ==========================================================
  // Padding widths; an odd chroma width is stored as written.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      luma_pad_ff <= '0;
      chroma_pad_ff <= '0;
    end
    else if (wr_commit && paddr == VBR_OFS_LUMA_PAD)
    begin
      luma_pad_ff <= pad_from(pwdata);
    end
    else if (wr_commit && paddr == VBR_OFS_CHROMA_PAD)
    begin
      chroma_pad_ff <= pad_from(pwdata);
    end
  end

  // ==========================================================
  // Effective settings: variant and coefficients gated by enables.
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ccv_en_out_ff <= 1'b0;
      src_var_ff <= 1'b0;
      res_var_ff <= 1'b0;
      range_ff <= '0;
    end
    else
    begin
      ccv_en_out_ff <= ccv_en_ff;
      src_var_ff <= ccv_en_ff && ccv_mode_ff[VBR_POS_SRC_VAR];
      res_var_ff <= ccv_en_ff && ccv_mode_ff[VBR_POS_RES_VAR];
      range_ff.chroma_en <= rm_c_en_ff;
      range_ff.chroma_coef <= rm_c_en_ff ? rm_c_coef_ff : '0;
      range_ff.luma_en <= rm_y_en_ff;
      range_ff.luma_coef <= rm_y_en_ff ? rm_y_coef_ff : '0;
    end
  end

  assign chroma_conv_enable = ccv_en_out_ff;
  assign chroma_conv_source_variant = src_var_ff;
  assign chroma_conv_result_variant = res_var_ff;
  assign range_cfg = range_ff;
  assign luma_pad = luma_pad_ff;
  assign chroma_pad = chroma_pad_ff;
  assign sel_pad = pad_is_chroma ? chroma_pad_ff : luma_pad_ff;

  // ==========================================================
  // Datapath helpers.
  // ==========================================================
  vbr_blend_pick u_pick (
    .pclk(pclk),
    .presetn(presetn),
    .lut(lut_ff),
    .bmp_index(bmp_index),
    .entry_ff(blend_entry)
  );

  vbr_pad_clamp #(.COORD_W(COORD_W)) u_clamp (
    .pclk(pclk),
    .presetn(presetn),
    .pad(sel_pad),
    .field_width(field_width),
    .field_height(field_height),
    .pad_x(pad_x),
    .pad_y(pad_y),
    .src_x_ff(src_x),
    .src_y_ff(src_y)
  );

  // ==========================================================
  // Checks.
  // ==========================================================
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  chk_apb_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready)
    else $error("Access phase not answered at once.");

  chk_lut_write_read: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && paddr == VBR_OFS_LUT2)) |=> lut_ff[2] == $past(pwdata))
    else $error("Blend entry two did not take the written word.");

  chk_src_variant: assert property (@(posedge pclk) disable iff (!presetn)
    chroma_conv_source_variant |-> $past(ccv_en_ff && ccv_mode_ff[VBR_POS_SRC_VAR]))
    else $error("Source variant set without enable and bit.");

  chk_res_variant: assert property (@(posedge pclk) disable iff (!presetn)
    !ccv_en_ff ##1 1'b1 |-> !chroma_conv_result_variant)
    else $error("Result variant leaks while conversion is off.");

  chk_chroma_coef_off: assert property (@(posedge pclk) disable iff (!presetn)
    !rm_c_en_ff |=> range_cfg.chroma_coef == '0 && !range_cfg.chroma_en)
    else $error("Chroma coefficient passed while mapping off.");

  chk_luma_coef_on: assert property (@(posedge pclk) disable iff (!presetn)
    rm_y_en_ff |=> range_cfg.luma_coef == $past(rm_y_coef_ff) && range_cfg.luma_en)
    else $error("Luma coefficient not passed while mapping on.");

  chk_range_write: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && paddr == VBR_OFS_RANGE))
    |=> rm_c_en_ff == $past(pwdata[11]) && rm_y_en_ff == $past(pwdata[3]))
    else $error("Range enables not written from bits 11 and 3.");

  chk_chroma_pad_fields: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access_done and (pwrite && paddr == VBR_OFS_CHROMA_PAD))
    |=> chroma_pad_ff.vert_total == $past(pwdata[13:8]))
    else $error("Chroma vertical width not taken from bits 13-8.");

endmodule : vbr_cfg_top

// File: verification/vbr_cfg_top_bench.sv
`timescale 1ns/10ps
module vbr_cfg_top_bench;
  import vbr_pkg::*;

  // ==========================================================
  // Stimulus and observed signals.
  // ==========================================================
  logic pclk = 1'b0; // Register clock, 20 MHz.
  logic presetn = 1'b0; // Active-low reset.
  logic [11:0] paddr = 12'h000; // APB address.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB enable.
  logic pwrite = 1'b0; // APB direction.
  logic [31:0] pwdata = 32'h0; // APB write data.
  logic [31:0] prdata; // APB read data.
  logic pready; // APB ready.
  logic pslverr; // APB error.
  logic [1:0] bmp_index = 2'h0; // Bitmap colour index.
  vbr_blend_t blend_entry; // Selected blend entry.
  logic ccv_en; // Chroma conversion enable.
  logic ccv_src; // Source variant.
  logic ccv_res; // Result variant.
  vbr_range_t range_cfg; // Effective range mapping.
  vbr_pad_t luma_pad; // Luma padding widths.
  vbr_pad_t chroma_pad; // Chroma padding widths.
  logic pad_is_chroma = 1'b0; // Plane of the replication request.
  logic [11:0] fw = 12'd10; // Field width.
  logic [11:0] fh = 12'd6; // Field height.
  logic [11:0] pad_x = 12'h0; // Padded column.
  logic [11:0] pad_y = 12'h0; // Padded row.
  logic [11:0] src_x; // Source column.
  logic [11:0] src_y; // Source row.
  int miscompares = 0; // Mismatches seen.
  int n_checks = 0; // Comparisons made.

  always #25 pclk = ~pclk;

  vbr_cfg_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bmp_index(bmp_index), .blend_entry(blend_entry),
    .chroma_conv_enable(ccv_en), .chroma_conv_source_variant(ccv_src),
    .chroma_conv_result_variant(ccv_res), .range_cfg(range_cfg), .luma_pad(luma_pad),
    .chroma_pad(chroma_pad), .pad_is_chroma(pad_is_chroma), .field_width(fw),
    .field_height(fh), .pad_x(pad_x), .pad_y(pad_y), .src_x(src_x), .src_y(src_y));

  // ==========================================================
  // Shared tasks.
  // ==========================================================
  // Prints the verdict and ends the run.
  task automatic test_done;
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Compares one observed value with its expectation.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // Lets one edge land and the flops settle.
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask : tick

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20)
    begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writes a register and expects no error.
  task automatic wreg(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
    chk("write error", {31'h0, err}, 32'h0);
  endtask : wreg

  // Reads a register and compares it.
  task automatic rreg(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h0, rd, err);
    chk(what, rd, exp);
  endtask : rreg

  // ==========================================================
  // Scenarios.
  // ==========================================================
  // Reset values, then an unmapped write and read.
  task automatic sc_reset;
    logic [31:0] rd;
    logic err;
    chk("blend after reset", blend_entry, 32'h0);
    chk("range after reset", {24'h0, range_cfg}, 32'h0);
    rreg("lut3 reset", VBR_OFS_LUT3, 32'h0);
    rreg("range reset", VBR_OFS_RANGE, 32'h0);
    rreg("luma pad reset", VBR_OFS_LUMA_PAD, 32'h0);
    rreg("chroma pad reset", VBR_OFS_CHROMA_PAD, 32'h0);
    apb(1'b1, 12'h0fc, 32'hffff_ffff, rd, err);
    chk("unmapped write error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h0fc, 32'h0, rd, err);
    chk("unmapped read error", {31'h0, err}, 32'h1);
    chk("unmapped read data", rd, 32'h0);
  endtask : sc_reset

  // Fills all four entries, reads them back, selects each index in turn.
  task automatic sc_blend;
    logic [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      wreg(VBR_OFS_LUT0 + 12'(4 * i), 32'hf0d0_b090 + 32'(i) * 32'h0102_0304);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 32'hf0d0_b090 + 32'(i) * 32'h0102_0304;
      rreg("lut readback", VBR_OFS_LUT0 + 12'(4 * i), v);
    end
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge pclk);
      bmp_index <= 2'(i);
      tick();
      v = 32'hf0d0_b090 + 32'(i) * 32'h0102_0304;
      chk("blend entry", blend_entry, v);
      chk("blend factor", {24'h0, blend_entry.blend_factor}, {24'h0, v[31:24]});
      chk("blend cr", {24'h0, blend_entry.blend_cr_value}, {24'h0, v[7:0]});
    end
  endtask : sc_blend

  // Writes enable and mode, then checks the effective variants.
  task automatic ccv_case(input logic en, input logic [1:0] mode);
    wreg(VBR_OFS_CCV_CTRL, {31'h0, en});
    wreg(VBR_OFS_CCV_MODE, {30'h0, mode});
    tick();
    chk("ccv enable", {31'h0, ccv_en}, {31'h0, en});
    chk("ccv source", {31'h0, ccv_src}, {31'h0, en & mode[1]});
    chk("ccv result", {31'h0, ccv_res}, {31'h0, en & mode[0]});
  endtask : ccv_case

  // Writes the range control and checks gating of the coefficients.
  task automatic range_case(input logic [31:0] w);
    logic [7:0] e;
    // The enables written here stand for the stream's range-map flags.
    wreg(VBR_OFS_RANGE, w);
    tick();
    e = {w[11], w[11] ? w[10:8] : 3'h0, w[3], w[3] ? w[2:0] : 3'h0};
    chk("range chroma", {28'h0, range_cfg[7:4]}, {28'h0, e[7:4]});
    chk("range luma", {28'h0, range_cfg[3:0]}, {28'h0, e[3:0]});
    rreg("range readback", VBR_OFS_RANGE, w & 32'h0000_0f0f);
  endtask : range_case

  // Drives one padded coordinate and checks the replicated source.
  task automatic pad_case(input logic ch, input int x, input int y, input int ex, input int ey);
    @(posedge pclk);
    pad_is_chroma <= ch;
    pad_x <= 12'(x);
    pad_y <= 12'(y);
    tick();
    chk("source x", {20'h0, src_x}, 32'(ex));
    chk("source y", {20'h0, src_y}, 32'(ey));
  endtask : pad_case

  // Padding widths, reserved bits and edge replication in both planes.
  task automatic sc_pad;
    wreg(VBR_OFS_LUMA_PAD, 32'hffff_ffff);
    rreg("luma pad full", VBR_OFS_LUMA_PAD, 32'h0000_3f3f);
    wreg(VBR_OFS_LUMA_PAD, 32'h0000_0803);
    // Software keeps the chroma horizontal width even.
    wreg(VBR_OFS_CHROMA_PAD, 32'h0000_0406);
    rreg("chroma pad", VBR_OFS_CHROMA_PAD, 32'h0000_0406);
    chk("luma pad out", {20'h0, luma_pad}, 32'h0000_0203);
    chk("chroma pad out", {20'h0, chroma_pad}, 32'h0000_0106);
    pad_case(1'b0, 0, 0, 0, 0);
    pad_case(1'b0, 3, 4, 0, 0);
    pad_case(1'b0, 5, 6, 2, 2);
    pad_case(1'b0, 20, 20, 9, 5);
    pad_case(1'b1, 5, 6, 0, 4);
    pad_case(1'b1, 8, 2, 2, 0);
  endtask : sc_pad

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    sc_reset();
    sc_blend();
    ccv_case(1'b0, 2'h3);
    ccv_case(1'b1, 2'h0);
    ccv_case(1'b1, 2'h2);
    ccv_case(1'b1, 2'h1);
    range_case(32'hffff_ffff);
    range_case(32'h0000_0507);
    range_case(32'h0000_0e03);
    range_case(32'h0000_060d);
    sc_pad();
    test_done();
  end

endmodule : vbr_cfg_top_bench
